/* File: include/lif_bus_if.sv */
// pins between the host controller and the line interface control port
`timescale 1ns/10ps
interface lif_bus_if;
  import lif_pkg::*;

  logic cs_n;
  logic sclk;
  logic shift_edge_choice;
  logic serial_in;
  logic serial_out;
  logic addr_latch_strobe;
  logic write_dir;
  logic data_strobe_n;
  logic ack_rdy;
  logic [7:0] ad_host;
  logic ad_host_oe_n;
  logic [7:0] ad_dev;
  logic ad_dev_oe_n;
  logic [7:0] ad;
  logic [1:0] mode;
  logic [1:0] loop_select;
  logic term_select;
  logic monitor_gain_choice;
  logic [3:0] line_shape_select;

  // resolved bus; undriven reads as the board pull-down
  assign ad = !ad_dev_oe_n ? ad_dev : (!ad_host_oe_n ? ad_host : 8'h00);

  modport dev (
    input cs_n, sclk, shift_edge_choice, serial_in, addr_latch_strobe, write_dir,
    input data_strobe_n, ad, mode, loop_select, term_select, monitor_gain_choice,
    input line_shape_select,
    output serial_out, ack_rdy, ad_dev, ad_dev_oe_n
  );

  modport host (
    output cs_n, sclk, shift_edge_choice, serial_in, addr_latch_strobe, write_dir,
    output data_strobe_n, ad_host, ad_host_oe_n, mode, loop_select, term_select,
    output monitor_gain_choice, line_shape_select,
    input serial_out, ack_rdy, ad
  );
endinterface : lif_bus_if

/* File: include/lif_pkg.sv */
// shared types and constants of the line interface host control port
package lif_pkg;

  // host port style, taken from the mode straps
  typedef enum logic [1:0] {ST_SERIAL, ST_RW_STROBE, ST_STB_DIR, ST_HARDWARE} lif_style_t;
  // loopback decode, in strap order
  typedef enum logic [1:0] {LOOP_NONE, LOOP_ANALOG, LOOP_DIGITAL, LOOP_REMOTE} lif_loop_t;
  typedef enum logic [1:0] {STD_E1, STD_T1, STD_J1} lif_std_t;
  typedef enum logic [1:0] {IMP_75, IMP_120, IMP_100, IMP_110} lif_imp_t;

  // timing
  localparam int LIF_CLK_NS = 20;
  localparam int LIF_SCLK_PERIOD_NS = 160;
  localparam int LIF_SCLK_HALF_CYC = LIF_SCLK_PERIOD_NS / (2 * LIF_CLK_NS);
  localparam int LIF_PH_NS = 80;
  localparam int LIF_PH_CYC = (LIF_PH_NS + LIF_CLK_NS - 1) / LIF_CLK_NS;
  localparam int LIF_ACC_CYC = 2;

  // serial frame: read flag, 7 address bits, 8 data bits, msb first
  localparam logic [3:0] LIF_SER_ADDR_LAST = 4'h7;
  localparam logic [3:0] LIF_SER_LAST = 4'hf;
  localparam logic [4:0] LIF_SER_DATA_FIRST = 5'h08;
  localparam logic [4:0] LIF_SER_DATA_LAST = 5'h0f;
  localparam logic [4:0] LIF_SER_TRAIL = 5'h10;

  // device registers, software control mode
  localparam logic [7:0] LIF_REG_CTRL = 8'h00;
  localparam logic [7:0] LIF_REG_SHAPE = 8'h01;
  localparam int LIF_CTRL_LOOP_LSB = 0;
  localparam int LIF_CTRL_INBAND = 2;
  localparam int LIF_CTRL_TERM = 3;
  localparam int LIF_CTRL_MON = 4;
  localparam int LIF_SHAPE_LSB = 0;
  localparam logic [7:0] LIF_REG_RST = 8'h00;
  localparam logic [3:0] LIF_SHAPE_T1_MIN = 4'h2;
  localparam logic [3:0] LIF_SHAPE_J1_MIN = 4'h8;

  // synchroniser reset levels: chip select, write_dir, data strobe and ack idle high; address latch strobe low
  localparam logic [24:0] LIF_DEV_SYNC_RST = 25'h10c0000;
  localparam logic [9:0] LIF_HOST_SYNC_RST = 10'h200;

  // host apb map
  localparam logic [11:0] LIF_APB_CFG = 12'h000;
  localparam logic [11:0] LIF_APB_CMD = 12'h004;
  localparam logic [11:0] LIF_APB_STAT = 12'h008;
  localparam logic [31:0] LIF_CFG_RST = 32'h00000000;
  localparam logic [31:0] LIF_CFG_MASK = 32'h00000f7f;
  localparam int LIF_CFG_STYLE_LSB = 0;
  localparam int LIF_CFG_EDGE = 2;
  localparam int LIF_CFG_LOOP_LSB = 3;
  localparam int LIF_CFG_TERM = 5;
  localparam int LIF_CFG_MON = 6;
  localparam int LIF_CFG_SHAPE_LSB = 8;
  localparam int LIF_CMD_ADDR_LSB = 0;
  localparam int LIF_CMD_DATA_LSB = 8;
  localparam int LIF_CMD_READ = 16;
  localparam int LIF_STAT_BUSY = 0;
  localparam int LIF_STAT_DATA_LSB = 8;

endpackage : lif_pkg

/* File: rtl/lif_dev_end.sv */
// device end of the line interface host control port
`timescale 1ns/10ps
module lif_dev_end import lif_pkg::*; #(
  parameter int REG_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host port pins
  lif_bus_if.dev bus,
  // line settings
  output lif_loop_t loop_mode,
  output logic inband_loop_en,
  output logic term_internal,
  output logic mon_gain_26db,
  output lif_std_t line_std,
  output logic [3:0] tx_template,
  output lif_imp_t term_imp
);
  localparam int AW = $clog2(REG_DEPTH);

  generate
    if (REG_DEPTH < 2 || REG_DEPTH > 128 || (REG_DEPTH & (REG_DEPTH - 1)) != 0) begin : g_chk
      $error("REG_DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  // every pin is asynchronous to clk
  logic [24:0] raw;
  logic [24:0] syn;
  logic cs_n_s, sclk_s, edge_s, sin_s, ale_s, wdir_s, dstb_n_s, term_s, mon_s;
  logic [1:0] mode_s;
  logic [1:0] loop_s;
  logic [3:0] shape_s;
  logic [7:0] ad_s;

  assign raw = {bus.cs_n, bus.sclk, bus.shift_edge_choice, bus.serial_in,
                bus.addr_latch_strobe, bus.write_dir, bus.data_strobe_n, bus.mode,
                bus.loop_select, bus.term_select, bus.monitor_gain_choice,
                bus.line_shape_select, bus.ad};

  lif_sync2 #(.W(25), .RST(LIF_DEV_SYNC_RST)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(raw),
    .q(syn)
  );

  assign {cs_n_s, sclk_s, edge_s, sin_s, ale_s, wdir_s, dstb_n_s, mode_s, loop_s,
          term_s, mon_s, shape_s, ad_s} = syn;

  lif_style_t style;
  logic sclk_q, ale_q;
  logic sclk_rise, sclk_fall, ale_fall;
  logic sel, ser_on, par_on, stb_act, is_rd, acc_on, acc_done;

  assign style = lif_style_t'(mode_s);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      ale_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      ale_q <= ale_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_q;
  assign sclk_fall = !sclk_s && sclk_q;
  assign ale_fall = ale_q && !ale_s;

  assign sel = !cs_n_s;
  assign ser_on = sel && (style == ST_SERIAL);
  assign par_on = sel && (style == ST_RW_STROBE || style == ST_STB_DIR);

  // strobe meaning per style
  always_comb begin
    if (style == ST_RW_STROBE) begin
      stb_act = !dstb_n_s || !wdir_s;
      is_rd = !dstb_n_s;
    end else begin
      stb_act = !dstb_n_s;
      is_rd = wdir_s;
    end
  end

  assign acc_on = par_on && stb_act;

  // register file
  logic [7:0] regs_r [REG_DEPTH];

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    rd_reg = (a < 8'(REG_DEPTH)) ? regs_r[a[AW-1:0]] : 8'h00;
  endfunction

  // serial shifter
  logic [3:0] ser_cnt_r;
  logic [6:0] ser_sh_r;
  logic ser_rd_r;
  logic [7:0] first_byte;
  logic [7:0] first_val;

  assign first_byte = {ser_sh_r, sin_s};
  assign first_val = rd_reg({1'b0, first_byte[6:0]});

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ser_cnt_r <= 4'h0;
      ser_sh_r <= 7'h00;
      ser_rd_r <= 1'b0;
    end else if (!ser_on) begin
      ser_cnt_r <= 4'h0;
      ser_rd_r <= 1'b0;
    end else if (sclk_rise) begin
      ser_cnt_r <= ser_cnt_r + 4'h1;
      ser_sh_r <= first_byte[6:0];
      if (ser_cnt_r == LIF_SER_ADDR_LAST) begin
        ser_rd_r <= first_byte[7];
      end
    end
  end

  // address latch, shared by both parallel styles and the serial frame
  logic [7:0] addr_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 8'h00;
    end else if (par_on && ale_fall) begin
      addr_r <= ad_s;
    end else if (ser_on && sclk_rise && ser_cnt_r == LIF_SER_ADDR_LAST) begin
      addr_r <= {1'b0, first_byte[6:0]};
    end
  end

  // access timer: fixed latency so ready really goes low first
  logic [1:0] acc_cnt_r;

  assign acc_done = (acc_cnt_r == 2'(LIF_ACC_CYC));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_cnt_r <= 2'h0;
    end else if (!acc_on) begin
      acc_cnt_r <= 2'h0;
    end else if (!acc_done) begin
      acc_cnt_r <= acc_cnt_r + 2'h1;
    end
  end

  logic wr_par, wr_ser;

  assign wr_par = acc_on && !is_rd && (acc_cnt_r == 2'(LIF_ACC_CYC - 1));
  assign wr_ser = ser_on && sclk_rise && (ser_cnt_r == LIF_SER_LAST) && !ser_rd_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_r[i] <= LIF_REG_RST;
      end
    end else if ((wr_par || wr_ser) && addr_r < 8'(REG_DEPTH)) begin
      regs_r[addr_r[AW-1:0]] <= wr_par ? ad_s : first_byte;
    end
  end

  // parallel bus outputs; disabled drive whenever not reading
  logic ack_rdy_r, ad_oe_n_r;
  logic [7:0] ad_out_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_rdy_r <= 1'b1;
    end else if (style == ST_RW_STROBE) begin
      ack_rdy_r <= !acc_on || acc_done;
    end else begin
      ack_rdy_r <= !(acc_on && acc_done);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ad_oe_n_r <= 1'b1;
      ad_out_r <= 8'h00;
    end else begin
      ad_oe_n_r <= !(acc_on && is_rd);
      ad_out_r <= rd_reg(addr_r);
    end
  end

  // serial output; with rising launch the first data bit leaves on the address edge
  logic sout_r;
  logic [7:0] sout_sh_r;
  logic launch;

  assign launch = edge_s ? sclk_fall : sclk_rise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sout_r <= 1'b0;
      sout_sh_r <= 8'h00;
    end else if (!ser_on) begin
      sout_r <= 1'b0;
      sout_sh_r <= 8'h00;
    end else if (sclk_rise && ser_cnt_r == LIF_SER_ADDR_LAST && first_byte[7]) begin
      if (!edge_s) begin
        sout_r <= first_val[7];
        sout_sh_r <= {first_val[6:0], 1'b0};
      end else begin
        sout_sh_r <= first_val;
      end
    end else if (launch) begin
      sout_r <= sout_sh_r[7];
      sout_sh_r <= {sout_sh_r[6:0], 1'b0};
    end
  end

  assign bus.serial_out = sout_r;
  assign bus.ack_rdy = ack_rdy_r;
  assign bus.ad_dev = ad_out_r;
  assign bus.ad_dev_oe_n = ad_oe_n_r;

  // line settings: straps in hardware mode (in-band loopback forced off there), registers otherwise
  function automatic lif_std_t shape_std(input logic [3:0] s);
    if (s < LIF_SHAPE_T1_MIN) begin
      shape_std = STD_E1;
    end else if (s < LIF_SHAPE_J1_MIN) begin
      shape_std = STD_T1;
    end else begin
      shape_std = STD_J1;
    end
  endfunction

  function automatic lif_imp_t shape_imp(input logic [3:0] s);
    case (shape_std(s))
      STD_E1: shape_imp = (s == 4'h0) ? IMP_75 : IMP_120;
      STD_T1: shape_imp = IMP_100;
      default: shape_imp = IMP_110;
    endcase
  endfunction

  logic hw;
  logic [7:0] ctrl;
  logic [3:0] shape_src;

  assign hw = (style == ST_HARDWARE);
  assign ctrl = regs_r[LIF_REG_CTRL[AW-1:0]];
  assign shape_src = hw ? shape_s : regs_r[LIF_REG_SHAPE[AW-1:0]][LIF_SHAPE_LSB +: 4];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loop_mode <= LOOP_NONE;
      inband_loop_en <= 1'b0;
      term_internal <= 1'b0;
      mon_gain_26db <= 1'b0;
    end else if (hw) begin
      loop_mode <= lif_loop_t'(loop_s);
      inband_loop_en <= 1'b0;
      term_internal <= term_s;
      mon_gain_26db <= mon_s;
    end else begin
      loop_mode <= lif_loop_t'(ctrl[LIF_CTRL_LOOP_LSB +: 2]);
      inband_loop_en <= ctrl[LIF_CTRL_INBAND];
      term_internal <= ctrl[LIF_CTRL_TERM];
      mon_gain_26db <= ctrl[LIF_CTRL_MON];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_std <= STD_E1;
      tx_template <= 4'h0;
      term_imp <= IMP_75;
    end else begin
      line_std <= shape_std(shape_src);
      tx_template <= shape_src;
      term_imp <= shape_imp(shape_src);
    end
  end
endmodule : lif_dev_end

/* File: rtl/lif_host_end.sv */
// host end: apb-programmed controller driving the line interface control port
`timescale 1ns/10ps
module lif_host_end import lif_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  lif_bus_if.host bus
);
  logic [9:0] raw;
  logic [9:0] syn;
  logic ack_s, sout_s;
  logic [7:0] ad_s;

  assign raw = {bus.ack_rdy, bus.serial_out, bus.ad};

  lif_sync2 #(.W(10), .RST(LIF_HOST_SYNC_RST)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(raw),
    .q(syn)
  );

  assign {ack_s, sout_s, ad_s} = syn;

  // apb registers; zero wait states
  logic [31:0] cfg_r;
  logic [7:0] cmd_addr_r, cmd_data_r, rdata_r;
  logic cmd_read_r, busy_r, go, fin;
  logic access, known;
  lif_style_t style;

  assign access = psel && penable;
  assign known = (paddr == LIF_APB_CFG) || (paddr == LIF_APB_CMD) || (paddr == LIF_APB_STAT);
  assign pready = 1'b1;
  assign pslverr = access && !known;
  assign go = access && pwrite && (paddr == LIF_APB_CMD) && !busy_r;
  assign style = lif_style_t'(cfg_r[LIF_CFG_STYLE_LSB +: 2]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        LIF_APB_CFG: prdata <= cfg_r;
        LIF_APB_CMD: prdata <= {15'h0000, cmd_read_r, cmd_data_r, cmd_addr_r};
        LIF_APB_STAT: prdata <= {16'h0000, rdata_r, 7'h00, busy_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= LIF_CFG_RST;
    end else if (access && pwrite && paddr == LIF_APB_CFG && !busy_r) begin
      cfg_r <= pwdata & LIF_CFG_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_addr_r <= 8'h00;
      cmd_data_r <= 8'h00;
      cmd_read_r <= 1'b0;
    end else if (go) begin
      cmd_addr_r <= pwdata[LIF_CMD_ADDR_LSB +: 8];
      cmd_data_r <= pwdata[LIF_CMD_DATA_LSB +: 8];
      cmd_read_r <= pwdata[LIF_CMD_READ];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (go) begin
      busy_r <= 1'b1;
    end else if (fin) begin
      busy_r <= 1'b0;
    end
  end

  // straps follow the configuration register
  assign bus.mode = cfg_r[LIF_CFG_STYLE_LSB +: 2];
  assign bus.shift_edge_choice = cfg_r[LIF_CFG_EDGE];
  assign bus.loop_select = cfg_r[LIF_CFG_LOOP_LSB +: 2];
  assign bus.term_select = cfg_r[LIF_CFG_TERM];
  assign bus.monitor_gain_choice = cfg_r[LIF_CFG_MON];
  assign bus.line_shape_select = cfg_r[LIF_CFG_SHAPE_LSB +: 4];

  // access sequencer
  typedef enum logic [2:0] {H_IDLE, H_SER_LO, H_SER_HI, H_ALE_HI, H_ALE_LO, H_STB, H_REL} lif_hst_t;
  lif_hst_t st_r;
  logic [3:0] tmr_r;
  logic [4:0] bit_r;
  logic [15:0] frame_r;
  logic seen_r, tdone, data_bit, pdone, go_q;
  logic cs_n_r, sclk_r, sin_r, ale_r, wdir_r, dstb_n_r, oe_n_r;
  logic [7:0] ad_r;

  assign tdone = (tmr_r == 4'(LIF_SCLK_HALF_CYC - 1));
  assign data_bit = (bit_r >= LIF_SER_DATA_FIRST) && (bit_r <= LIF_SER_DATA_LAST);
  assign pdone = (tmr_r == 4'(LIF_PH_CYC - 1));
  assign fin = (st_r == H_IDLE && go_q) || (st_r == H_SER_LO && tdone && bit_r == LIF_SER_TRAIL)
               || (st_r == H_REL && pdone);

  // commands in hardware style finish at once

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go && style == ST_HARDWARE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= H_IDLE;
      tmr_r <= 4'h0;
      bit_r <= 5'h00;
      frame_r <= 16'h0000;
      seen_r <= 1'b0;
      rdata_r <= 8'h00;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sin_r <= 1'b0;
      ale_r <= 1'b0;
      wdir_r <= 1'b1;
      dstb_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      ad_r <= 8'h00;
    end else begin
      tmr_r <= tmr_r + 4'h1;
      case (st_r)
        H_IDLE: begin
          tmr_r <= 4'h0;
          bit_r <= 5'h00;
          seen_r <= 1'b0;
          if (busy_r && !go_q && style == ST_SERIAL) begin
            cs_n_r <= 1'b0;
            frame_r <= {cmd_read_r, cmd_addr_r[6:0], cmd_data_r};
            sin_r <= cmd_read_r;
            st_r <= H_SER_LO;
          end else if (busy_r && !go_q && style != ST_HARDWARE) begin
            cs_n_r <= 1'b0;
            ad_r <= cmd_addr_r;
            oe_n_r <= 1'b0;
            ale_r <= 1'b1;
            wdir_r <= (style == ST_STB_DIR) ? cmd_read_r : 1'b1;
            st_r <= H_ALE_HI;
          end
        end
        H_SER_LO: begin
          if (tdone) begin
            tmr_r <= 4'h0;
            if (!bus.shift_edge_choice && data_bit && cmd_read_r) begin
              rdata_r <= {rdata_r[6:0], sout_s};
            end
            if (bit_r == LIF_SER_TRAIL) begin
              cs_n_r <= 1'b1;
              sin_r <= 1'b0;
              st_r <= H_IDLE;
            end else begin
              sclk_r <= 1'b1;
              st_r <= H_SER_HI;
            end
          end
        end
        H_SER_HI: begin
          if (tdone) begin
            tmr_r <= 4'h0;
            if (bus.shift_edge_choice && data_bit && cmd_read_r) begin
              rdata_r <= {rdata_r[6:0], sout_s};
            end
            sclk_r <= 1'b0;
            bit_r <= bit_r + 5'h01;
            sin_r <= frame_r[14];
            frame_r <= {frame_r[14:0], 1'b0};
            st_r <= H_SER_LO;
          end
        end
        H_ALE_HI: begin
          if (pdone) begin
            tmr_r <= 4'h0;
            ale_r <= 1'b0;
            st_r <= H_ALE_LO;
          end
        end
        H_ALE_LO: begin
          if (pdone) begin
            tmr_r <= 4'h0;
            ad_r <= cmd_data_r;
            oe_n_r <= cmd_read_r;
            if (style == ST_RW_STROBE && !cmd_read_r) begin
              wdir_r <= 1'b0;
            end else begin
              dstb_n_r <= 1'b0;
            end
            st_r <= H_STB;
          end
        end
        H_STB: begin
          if (!ack_s) begin
            seen_r <= 1'b1;
          end
          // ready must be seen low first; it idles high
          if ((style == ST_RW_STROBE) ? (seen_r && ack_s) : !ack_s) begin
            tmr_r <= 4'h0;
            if (cmd_read_r) begin
              rdata_r <= ad_s;
            end
            dstb_n_r <= 1'b1;
            if (style == ST_RW_STROBE) begin
              wdir_r <= 1'b1;
            end
            st_r <= H_REL;
          end
        end
        H_REL: begin
          if (pdone) begin
            cs_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            wdir_r <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.cs_n = cs_n_r;
  assign bus.sclk = sclk_r;
  assign bus.serial_in = sin_r;
  assign bus.addr_latch_strobe = ale_r;
  assign bus.write_dir = wdir_r;
  assign bus.data_strobe_n = dstb_n_r;
  assign bus.ad_host = ad_r;
  assign bus.ad_host_oe_n = oe_n_r;
endmodule : lif_host_end

/* File: rtl/lif_sync2.sv */
// two flip-flop synchroniser with a per-bit reset level
`timescale 1ns/10ps
module lif_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : lif_sync2

/* File: test/lif_checker.sv */
// pin-level assertions for the host control port
`timescale 1ns/10ps
module lif_checker import lif_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // port pins
  input wire logic cs_n,
  input wire logic [1:0] mode,
  input wire logic write_dir,
  input wire logic data_strobe_n,
  input wire logic ack_rdy,
  input wire logic ad_dev_oe_n,
  input wire logic serial_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // pins pass two sync flops, so allow a few idle samples
  AST_DESEL_BUS: assert property (cs_n [*5] |-> ad_dev_oe_n)
    else $error("bus driven while deselected");
  AST_DESEL_SO: assert property (cs_n [*5] |-> !serial_out)
    else $error("serial out active while deselected");
  AST_DESEL_ACK: assert property (cs_n [*5] |-> ack_rdy)
    else $error("ack or ready low while deselected");
  AST_DRV_CAUSE: assert property ($fell(ad_dev_oe_n) |-> !data_strobe_n && !cs_n && write_dir)
    else $error("bus driven without a read strobe");
  AST_DRV_HOLD: assert property (!ad_dev_oe_n && !data_strobe_n |=> !ad_dev_oe_n)
    else $error("read drive dropped during strobe");
  AST_RELEASE: assert property (data_strobe_n [*5] |-> ad_dev_oe_n)
    else $error("bus still driven after strobe");
  AST_RDY_PULSE: assert property (mode == ST_RW_STROBE && $fell(ack_rdy) |->
    !cs_n && (!data_strobe_n || !write_dir) ##1 !ack_rdy ##[1:3] ack_rdy)
    else $error("ready pulse wrong");
  AST_ACK_HOLD: assert property (mode == ST_STB_DIR && !ack_rdy && !data_strobe_n |=> !ack_rdy)
    else $error("ack released during strobe");
  AST_ACK_CAUSE: assert property (mode == ST_STB_DIR && $fell(ack_rdy) |->
    !data_strobe_n && !cs_n)
    else $error("ack without strobe");
endmodule : lif_checker

/* File: test/test_lineif_host_control_port.sv */
// self-checking bench: host end and device end back to back
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module test_lineif_host_control_port import lif_pkg::*; ;
  localparam logic [3:0] SH [6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'hf};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, perr;
  lif_loop_t loop_mode;
  logic inband_loop_en, term_internal, mon_gain_26db;
  lif_std_t line_std;
  logic [3:0] tx_template;
  lif_imp_t term_imp;
  int fails = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  lif_bus_if bus();
  lif_dev_end u_lif_dev_end (.clk(clk), .rstn(rstn), .bus(bus.dev), .loop_mode(loop_mode),
    .inband_loop_en(inband_loop_en), .term_internal(term_internal),
    .mon_gain_26db(mon_gain_26db), .line_std(line_std), .tx_template(tx_template),
    .term_imp(term_imp));
  lif_host_end u_lif_host_end (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus.host));
  lif_checker u_lif_checker (.clk(clk), .rstn(rstn), .cs_n(bus.cs_n), .mode(bus.mode),
    .write_dir(bus.write_dir), .data_strobe_n(bus.data_strobe_n), .ack_rdy(bus.ack_rdy),
    .ad_dev_oe_n(bus.ad_dev_oe_n), .serial_out(bus.serial_out));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // entered just after a rising edge; leaves one idle cycle behind
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wait_idle;
    int k;
    for (k = 0; k < 500; k++) begin
      apb(1'b0, LIF_APB_STAT, 32'h0);
      if (r[LIF_STAT_BUSY] === 1'b0) break;
    end
    `CHK(r[LIF_STAT_BUSY], 1'b0)
  endtask : wait_idle
  task test_regs;
    apb(1'b0, LIF_APB_CFG, 32'h0);
    `CHK(r, LIF_CFG_RST)
    `CHK(perr, 1'b0)
    apb(1'b1, LIF_APB_CFG, 32'hffffffff);
    apb(1'b0, LIF_APB_CFG, 32'h0);
    `CHK(r, LIF_CFG_MASK)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(perr, 1'b1)
    apb(1'b1, LIF_APB_CFG, 32'h0);
    $display("test regs done");
  endtask : test_regs
  // write a device register, read it back through the same style
  task xfer(input logic [1:0] st, input logic ed, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, LIF_APB_CFG, {29'h0, ed, st});
    apb(1'b1, LIF_APB_CMD, {16'h0, d, a});
    wait_idle();
    apb(1'b1, LIF_APB_CMD, {15'h0, 1'b1, 8'h00, a});
    wait_idle();
    `CHK(r[15:8], d)
    $display("test xfer style %0d edge %0d done", st, ed);
  endtask : xfer
  task test_hw;
    int k;
    logic [1:0] lp;
    for (k = 0; k < 6; k++) begin
      lp = k[1:0];
      apb(1'b1, LIF_APB_CFG, {20'h0, SH[k], 1'b0, lp[1], lp[0] ^ lp[1], lp, 1'b0, ST_HARDWARE});
      repeat (6) @(posedge clk);
      `CHK(loop_mode, lif_loop_t'(lp))
      `CHK(inband_loop_en, 1'b0)
      `CHK(term_internal, lp[0] ^ lp[1])
      `CHK(mon_gain_26db, lp[1])
      `CHK(tx_template, SH[k])
      `CHK(line_std, SH[k] < 4'h2 ? STD_E1 : SH[k] < 4'h8 ? STD_T1 : STD_J1)
      `CHK(term_imp, SH[k] == 4'h0 ? IMP_75 : SH[k] == 4'h1 ? IMP_120 :
        SH[k] < 4'h8 ? IMP_100 : IMP_110)
    end
    $display("test hardware straps done");
  endtask : test_hw
  // line settings come from device registers outside hardware style
  task test_sw;
    xfer(ST_STB_DIR, 1'b0, LIF_REG_CTRL, 8'h1e);
    xfer(ST_RW_STROBE, 1'b0, LIF_REG_SHAPE, 8'h09);
    `CHK(loop_mode, LOOP_DIGITAL)
    `CHK(inband_loop_en, 1'b1)
    `CHK(term_internal, 1'b1)
    `CHK(mon_gain_26db, 1'b1)
    `CHK(tx_template, 4'h9)
    `CHK(line_std, STD_J1)
    `CHK(term_imp, IMP_110)
    $display("test register settings done");
  endtask : test_sw
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    test_regs();
    xfer(ST_SERIAL, 1'b0, 8'h05, 8'ha5);
    xfer(ST_SERIAL, 1'b1, 8'h06, 8'h3c);
    xfer(ST_RW_STROBE, 1'b0, 8'h09, 8'h5a);
    xfer(ST_RW_STROBE, 1'b0, 8'h0f, 8'hff);
    xfer(ST_STB_DIR, 1'b0, 8'h0a, 8'hc3);
    xfer(ST_STB_DIR, 1'b0, 8'h02, 8'h81);
    test_sw();
    test_hw();
    summarize();
  end
  // a full run takes well under this
  initial begin
    #400us;
    fails++;
    summarize();
  end
endmodule : test_lineif_host_control_port
